// >>> src/fts_pkg.sv
/*
 * Package of the frame time stamp output block: register offsets, field positions
 * and reset values of the three control registers that steer the stamp pin.
 * Assumes an 8-bit register port with byte offsets as used by the host.
 */
`default_nettype none

package fts_pkg;

    // Register offsets on the host register port.
    localparam logic [7:0] FTS_OFS_TRX_CTRL_ONE  = 8'h04;
    localparam logic [7:0] FTS_OFS_EXT_MODE_ONE  = 8'h17;
    localparam logic [7:0] FTS_OFS_ANT_DIV       = 8'h0D;

    // Field positions.
    localparam int unsigned FTS_BIT_STAMP_PIN_EN = 6;
    localparam int unsigned FTS_BIT_RETRY_TX_EN  = 7;
    localparam int unsigned FTS_BIT_ANT_SW_EN    = 2;
    localparam int unsigned FTS_BIT_ANT_CTRL_LO  = 0;

    // Reset values of the registers.
    localparam logic [7:0] FTS_RST_TRX_CTRL_ONE  = 8'h22;
    localparam logic [7:0] FTS_RST_EXT_MODE_ONE  = 8'h00;
    localparam logic [7:0] FTS_RST_ANT_DIV       = 8'h00;

    // Reserved bit masks: bit 3 of the extended register reads zero.
    localparam logic [7:0] FTS_MASK_EXT_MODE_ONE = 8'hF7;
    localparam logic [7:0] FTS_MASK_ANT_DIV      = 8'h0F;

    // Static antenna control codes.
    localparam logic [1:0] FTS_ANT_ZERO          = 2'h1;
    localparam logic [1:0] FTS_ANT_ONE           = 2'h2;

    // Pin state machine, one-hot.
    typedef enum logic [2:0]
    {
        FTS_IDLE  = 3'b001,
        FTS_RX    = 3'b010,
        FTS_TX    = 3'b100
    } fts_state_t;

    // All state of the block.
    typedef struct packed
    {
        fts_state_t state;
        logic [7:0] trx_ctrl_one;
        logic [7:0] ext_mode_one;
        logic [7:0] ant_div;
        logic       pin;
        logic [7:0] rd_data;
    } fts_regs_t;

endpackage

`default_nettype wire

// >>> src/fts_stamp.sv
/*
 * Frame time stamp output: drives the shared time stamp pin high from a valid
 * header or an auto retry transmit start until the end of the frame, and otherwise hands the
 * pin to the antenna switch control or pulls it low.
 * Assumes frame events arrive as one-cycle pulses from logic on clk_sys and that
 * register accesses come from the host register port in the same clock domain.
 */
// What this block does
// - Pin rises on valid header or transmit start.
// - Pin stays high until frame procedure ends.
// - Receive any mode; transmit only auto retry.
// - Unused pin is pulled low to ground.
// - Stamp enable at bit 6, offset 0x04.
// - Pin works regardless of receive interrupt mask.
// - Retry stamp enable at bit 7, 0x17.
// - Stamping takes over pin from antenna switch.
`default_nettype none

module fts_stamp
(
    // Clock, reset and clock enable.
    input  wire logic       clk_sys,
    input  wire logic       srst,
    input  wire logic       clk_en,
    // Host register port.
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Transceiver frame events as one-cycle pulses, and the auto retry mode level.
    input  wire logic       rx_header_valid,
    input  wire logic       rx_frame_end,
    input  wire logic       tx_frame_start,
    input  wire logic       tx_frame_end,
    input  wire logic       auto_retry_transmit_mode,
    // Receive-start interrupt mask bit, shown only to prove it has no effect.
    input  wire logic       rx_start_irq_mask,
    // Time stamp pin.
    output logic            time_stamp_pin,
    output logic            time_stamp_pin_oe
);

    // Current and next state.
    fts_pkg::fts_regs_t cur;
    fts_pkg::fts_regs_t next_cur;

    // Decoded enables.
    logic stamp_pin_enable;
    logic retry_tx_stamp_enable;
    logic antenna_switch_drive_enable;
    logic ant_level;

    // Read decode shared by the read path.
    function automatic logic [7:0] read_reg(input fts_pkg::fts_regs_t s,
                                            input logic [7:0] addr);
        case (addr)
            fts_pkg::FTS_OFS_TRX_CTRL_ONE: read_reg = s.trx_ctrl_one;
            fts_pkg::FTS_OFS_EXT_MODE_ONE: read_reg = s.ext_mode_one;
            fts_pkg::FTS_OFS_ANT_DIV:      read_reg = s.ant_div;
            default:                       read_reg = 8'h00;
        endcase
    endfunction

    // Field decode of the stored registers.
    always_comb
    begin
        stamp_pin_enable      = cur.trx_ctrl_one[fts_pkg::FTS_BIT_STAMP_PIN_EN];
        retry_tx_stamp_enable = cur.ext_mode_one[fts_pkg::FTS_BIT_RETRY_TX_EN];
        antenna_switch_drive_enable = cur.ant_div[fts_pkg::FTS_BIT_ANT_SW_EN];
        // Antenna zero drives the pin high, antenna one low.
        ant_level = (cur.ant_div[fts_pkg::FTS_BIT_ANT_CTRL_LO +: 2] == fts_pkg::FTS_ANT_ZERO);
    end

    // Next-state logic: registers, frame tracking and pin level.
    always_comb
    begin
        next_cur = cur;
        // Register writes.
        if (reg_wr)
        begin
            case (reg_addr)
                fts_pkg::FTS_OFS_TRX_CTRL_ONE: next_cur.trx_ctrl_one = reg_wdata;
                fts_pkg::FTS_OFS_EXT_MODE_ONE:
                    next_cur.ext_mode_one = reg_wdata & fts_pkg::FTS_MASK_EXT_MODE_ONE;
                fts_pkg::FTS_OFS_ANT_DIV:
                    next_cur.ant_div = reg_wdata & fts_pkg::FTS_MASK_ANT_DIV;
                default: ;
            endcase
        end
        // Read data held in a flip-flop.
        if (reg_rd)
        begin
            next_cur.rd_data = read_reg(cur, reg_addr);
        end
        // Frame tracking; the interrupt mask is never consulted.
        case (cur.state)
            fts_pkg::FTS_IDLE:
            begin
                if (stamp_pin_enable && rx_header_valid)
                begin
                    next_cur.state = fts_pkg::FTS_RX;
                end
                else if (stamp_pin_enable && retry_tx_stamp_enable
                         && auto_retry_transmit_mode && tx_frame_start)
                begin
                    next_cur.state = fts_pkg::FTS_TX;
                end
            end
            fts_pkg::FTS_RX:
            begin
                if (rx_frame_end || !stamp_pin_enable)
                begin
                    next_cur.state = fts_pkg::FTS_IDLE;
                end
            end
            fts_pkg::FTS_TX:
            begin
                if (tx_frame_end || !stamp_pin_enable)
                begin
                    next_cur.state = fts_pkg::FTS_IDLE;
                end
            end
            default: next_cur.state = fts_pkg::FTS_IDLE;
        endcase
        // Pin level: stamping wins, then antenna switch, else ground.
        if (stamp_pin_enable)
        begin
            next_cur.pin = (next_cur.state != fts_pkg::FTS_IDLE);
        end
        else if (antenna_switch_drive_enable)
        begin
            next_cur.pin = ant_level;
        end
        else
        begin
            next_cur.pin = 1'b0;
        end
    end

    // State register with synchronous reset and clock enable.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            cur.state        <= fts_pkg::FTS_IDLE;
            cur.trx_ctrl_one <= fts_pkg::FTS_RST_TRX_CTRL_ONE;
            cur.ext_mode_one <= fts_pkg::FTS_RST_EXT_MODE_ONE;
            cur.ant_div      <= fts_pkg::FTS_RST_ANT_DIV;
            cur.pin          <= 1'b0;
            cur.rd_data      <= 8'h00;
        end
        else if (clk_en)
        begin
            cur <= next_cur;
        end
    end

    // Outputs; the pin is always driven, low when unused.
    // Driving it low rather than releasing it keeps the host input from floating.
    assign reg_rdata         = cur.rd_data;
    assign time_stamp_pin    = cur.pin;
    assign time_stamp_pin_oe = 1'b1;

    // Receive stamp: an enabled header in idle raises the pin one edge later.
    a_rx_rise: assert property (@(posedge clk_sys) disable iff (srst)
        clk_en && cur.state == fts_pkg::FTS_IDLE && stamp_pin_enable && rx_header_valid
        && !reg_wr |=> time_stamp_pin)
        else $error("pin did not rise on header");

    // Pin stays high while in a receive frame without end or disable.
    // A cleared enable is seen one edge after its write, so it must be part of the
    // antecedent: the frame legally ends on that edge without an end pulse.
    a_frame_hold: assert property (@(posedge clk_sys) disable iff (srst)
        clk_en && cur.state == fts_pkg::FTS_RX && !rx_frame_end && !reg_wr
        && stamp_pin_enable |=> time_stamp_pin)
        else $error("pin fell during frame");

    // No transmit stamp outside auto retry mode.
    a_tx_mode: assert property (@(posedge clk_sys) disable iff (srst)
        cur.state == fts_pkg::FTS_IDLE && !auto_retry_transmit_mode && !rx_header_valid
        |=> cur.state != fts_pkg::FTS_TX)
        else $error("transmit stamp outside retry mode");

    // Unused pin is low.
    // The pin level is chosen from the stored enables, not from a pending write,
    // so the check looks at the enables that the next pin value really uses.
    a_pin_ground: assert property (@(posedge clk_sys) disable iff (srst)
        clk_en && !stamp_pin_enable && !antenna_switch_drive_enable
        |=> !time_stamp_pin)
        else $error("unused pin not grounded");

    // Stamp enable write reads back at bit 6.
    a_enable_bit: assert property (@(posedge clk_sys) disable iff (srst)
        clk_en && reg_wr && reg_addr == fts_pkg::FTS_OFS_TRX_CTRL_ONE
        |=> stamp_pin_enable == $past(reg_wdata[fts_pkg::FTS_BIT_STAMP_PIN_EN]))
        else $error("stamp enable bit not stored");

    // The interrupt mask does not stop the pin.
    a_mask_free: assert property (@(posedge clk_sys) disable iff (srst)
        clk_en && !rx_start_irq_mask && cur.state == fts_pkg::FTS_IDLE && stamp_pin_enable
        && rx_header_valid && !reg_wr |=> time_stamp_pin)
        else $error("mask blocked the pin");

    // Transmit stamp requires retry enable.
    a_tx_enable: assert property (@(posedge clk_sys) disable iff (srst)
        cur.state == fts_pkg::FTS_IDLE && !retry_tx_stamp_enable && !rx_header_valid
        |=> cur.state != fts_pkg::FTS_TX)
        else $error("transmit stamp without enable");

    // Stamping overrides the antenna switch level.
    a_pin_owner: assert property (@(posedge clk_sys) disable iff (srst)
        stamp_pin_enable |-> time_stamp_pin == (cur.state != fts_pkg::FTS_IDLE)
        || $changed(cur.trx_ctrl_one))
        else $error("antenna drove stamped pin");

    // Pin changes only on a clock-enabled edge or a reset edge.
    a_pin_reg: assert property (@(posedge clk_sys) disable iff (srst)
        !$past(clk_en) && !$past(srst) |-> $stable(time_stamp_pin))
        else $error("pin changed without enable");

endmodule

`default_nettype wire

// >>> verification/frame_time_stamp_output_bench.sv
/* Bench of the stamp pin block: row-driven frame events, then register and pin-sharing cases.
   Assumes fts_stamp and fts_pkg are compiled first and one 100 MHz clock. */
`default_nettype none
module frame_time_stamp_output_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // Row: header, rx end, tx start, tx end, retry mode, irq mask, expected pin.
    typedef struct packed {logic hv, re, ts, te, ar, mk, pin;} fts_row_t;
    fts_row_t   rows [8] = '{7'h41, 7'h01, 7'h20, 7'h15, 7'h05, 7'h0C, 7'h10, 7'h43};
    logic       clk_sys = 1'b0, srst = 1'b1, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rise_count;
    logic       hv = 1'b0, re = 1'b0, ts = 1'b0, te = 1'b0, ar = 1'b0, mk = 1'b0;
    logic       time_stamp_pin, time_stamp_pin_oe;
    int         bad_count = 0, cmp_count = 0, cyc = 0;
    fts_stamp dut (.clk_sys(clk_sys), .srst(srst), .clk_en(clk_en), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .rx_header_valid(hv), .rx_frame_end(re), .tx_frame_start(ts), .tx_frame_end(te),
        .auto_retry_transmit_mode(ar), .rx_start_irq_mask(mk),
        .time_stamp_pin(time_stamp_pin), .time_stamp_pin_oe(time_stamp_pin_oe));
    fts_capture cap (.clk_sys(clk_sys), .srst(srst), .pin(time_stamp_pin),
        .rise_count(rise_count));
    // Clock of 10 ns period.
    always #5 clk_sys = ~clk_sys;
    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Cuts a hang short well past the expected length of the run.
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    // Compares one pin level.
    task automatic chk_bit(input logic got, input logic exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    // Compares one byte.
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    // One-cycle register write.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask
    // One-cycle register read; data is looked at just after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Applies the row's events for a single cycle and leaves retry mode and irq mask at the row's levels; the pin is checked after the taking edge.
    task automatic step(input fts_row_t r);
        @(posedge clk_sys);
        {hv, re, ts, te, ar, mk} <= {r.hv, r.re, r.ts, r.te, r.ar, r.mk};
        @(posedge clk_sys);
        {hv, re, ts, te} <= 4'h0;
        #1;
    endtask
    logic [7:0] d;
    // Main sequence.
    initial
    begin
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        rd(8'h04, d); chk_byte(d, 8'h22, "ctrl reset");
        rd(8'h17, d); chk_byte(d, 8'h00, "ext reset");
        rd(8'h30, d); chk_byte(d, 8'h00, "unmapped");
        chk_bit(time_stamp_pin, 1'b0, "idle pin");
        chk_bit(time_stamp_pin_oe, 1'b1, "pin driven");
        step(7'h55); chk_bit(time_stamp_pin, 1'b0, "stamp off rx");
        wr(8'h17, 8'hFF); rd(8'h17, d); chk_byte(d, 8'hF7, "ext rw");
        step(7'h15); chk_bit(time_stamp_pin, 1'b0, "one bit only tx");
        wr(8'h04, 8'h62);
        step(7'h0C);
        for (int i = 0; i < 8; i++)
        begin
            step(rows[i]);
            chk_bit(time_stamp_pin, rows[i].pin, "row pin");
        end
        step(7'h20);
        chk_byte(rise_count, 8'h03, "host edges");
        $display("Frame rows done");
        // A low clock enable must hold the pin and the registers as they are.
        @(posedge clk_sys);
        clk_en <= 1'b0;
        step(7'h40);
        wr(8'h04, 8'h22);
        chk_bit(time_stamp_pin, 1'b0, "frozen pin");
        @(posedge clk_sys);
        clk_en <= 1'b1;
        rd(8'h04, d);
        chk_byte(d, 8'h62, "frozen write");
        $display("Clock enable case done");
        wr(8'h04, 8'h22); wr(8'h0D, 8'h05); step(7'h00);
        chk_bit(time_stamp_pin, 1'b1, "antenna drive");
        wr(8'h04, 8'h62); step(7'h00);
        chk_bit(time_stamp_pin, 1'b0, "stamp takes pin");
        step(7'h40);
        wr(8'h0D, 8'h06);
        chk_bit(time_stamp_pin, 1'b1, "stamp over antenna");
        wr(8'h04, 8'h22);
        step(7'h00);
        chk_bit(time_stamp_pin, 1'b0, "disable to antenna");
        @(posedge clk_sys); srst <= 1'b1;
        @(posedge clk_sys); srst <= 1'b0;
        #1; chk_bit(time_stamp_pin, 1'b0, "reset pin");
        rd(8'h0D, d); chk_byte(d, 8'h00, "antenna reset");
        rd(8'h04, d);
        chk_byte(d, 8'h22, "ctrl after reset");
        $display("Register and sharing cases done");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verification/fts_capture.sv
/* Host timer capture model: counts rising edges of the stamp pin.
   Assumes the pin is a registered level in the clk_sys domain. */
`default_nettype none
module fts_capture
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Observed stamp pin.
    input  wire logic       pin,
    // Number of rising edges seen since reset.
    output logic      [7:0] rise_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev; // Pin level one cycle earlier.
    // A capture input only sees edges, so stray highs between frames show up as extra counts.
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            prev <= 1'b0;
            rise_count <= 8'h00;
        end
        else
        begin
            prev <= pin;
            if (pin && !prev)
                rise_count <= rise_count + 8'h01;
        end
    end
endmodule
`default_nettype wire
